// ### chit_pkg.sv
// Notes on behaviour
// RL1 - non-zero initial status aborts to error exit
// RL2 - init sets transfer, input flags, loads count-1
// RL3 - after init, drop service-out, begin data phase
// RL4 - service-in steered to transfer logic by flags
// RL5 - wait settle delay after service-in rises
// RL6 - rank-one strobe loads byte, sets capture flag
// RL7 - capture flag lets service-in raise service-out
// RL8 - service-out sets rank-one-full; fires rank-two strobe (code sets the flag only while odd_byte_i is high)
// RL9 - rank-two strobe requests slice, moves byte up
// RL10 - adapter drops service-in, re-raises after service-out drops
// RL11 - service-in fall clears service-out flag
// RL12 - service-out fall advances byte count by one
// RL13 - granted slice runs six-step store routine
// RL14 - routine bumps address, compares, frees processor
// RL15 - address match raises transfer exit
// RL16 - rank-two read or output write pulses access
// RL17 - access pulse clears transfer request flag
// RL18 - rank-two strobe inhibited while request set
// RL19 - stop answers service-in with command-out
// RL20 - delays and pulses are rounded-up clock counts
// RL21 - service-in synchronised before edge detection
package chit_pkg;
    // clock period in picoseconds (200 mhz)
    localparam int CLK_PERIOD_PS = 5000;
    // documented times in nanoseconds
    localparam int SETTLE_NS = 185;
    localparam int STROBE_NS = 55;
    localparam int ACCESS_NS = 30;
    // cycle counts, rounded up so nothing runs short
    localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // width of the delay and pulse counters
    localparam int TMR_W = 6;
    // default widths of byte, count and address
    localparam int DATA_W = 8;
    localparam int COUNT_W = 16;
    localparam int ADDR_W = 16;
    // steps of the per-byte store routine
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_READ,
        ST_SUM,
        ST_WRA,
        ST_WRB,
        ST_CMP
    } chit_step_t;
endpackage

// ### chit_buf.sv
`timescale 1ns/1ps
// two-entry buffer: output register plus one skid entry
module chit_buf #(
    parameter int W = 24
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // filling side
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    // draining side
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    logic skid_valid; // second entry occupied
    logic [W-1:0] skid_data; // second entry contents
    logic in_fire; // word accepted this cycle

    // refuse input only when both entries hold words
    assign in_ready_o = ~skid_valid;
    assign in_fire = in_valid_i & ~skid_valid;

    // move words forward, park one when output stalls
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
            skid_valid <= 1'b0;
            skid_data <= '0;
        end else if (out_ready_i || !out_valid_o) begin
            // output free: refill from skid first
            if (skid_valid) begin
                out_data_o <= skid_data;
                out_valid_o <= 1'b1;
                skid_valid <= 1'b0;
            end else begin
                out_valid_o <= in_fire;
                if (in_fire) begin
                    out_data_o <= in_data_i;
                end
            end
        end else if (in_fire) begin
            // output stalled: hold word in skid
            skid_valid <= 1'b1;
            skid_data <= in_data_i;
        end
    end
endmodule

// ### chit_top.sv
`timescale 1ns/1ps
// hardware-controlled input byte transfer of a selector channel
module chit_top #(
    parameter int DW = chit_pkg::DATA_W,
    parameter int CW = chit_pkg::COUNT_W,
    parameter int AW = chit_pkg::ADDR_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // initialisation from the selection sequence
    input wire logic start_i,
    input wire logic [DW-1:0] init_status_i,
    input wire logic [CW-1:0] req_count_i,
    input wire logic [AW-1:0] first_addr_i,
    input wire logic [AW-1:0] last_addr_i,
    // channel configuration levels
    input wire logic odd_byte_i,
    input wire logic adapter_selected_i,
    input wire logic stop_i,
    // adapter pins
    input wire logic svc_in_tag_i,
    input wire logic [DW-1:0] bus_in_i,
    input wire logic bus_par_i,
    output logic svc_out_tag_o,
    output logic cmd_out_tag_o,
    // processor side
    input wire logic slice_grant_i,
    input wire logic out_rank_wr_i,
    input wire logic [DW-1:0] out_rank_data_i,
    output logic slice_request_o,
    output logic tag_request_o,
    output logic proc_busy_o,
    output logic reg_access_o,
    output logic error_exit_o,
    output logic xfer_exit_o,
    output logic check_o,
    output logic [CW-1:0] byte_count_o,
    output logic [DW-1:0] output_rank_one_o,
    // main storage write stream
    output logic mem_valid_o,
    output logic [AW-1:0] mem_addr_o,
    output logic [DW-1:0] mem_data_o,
    input wire logic mem_ready_i
);
    localparam logic [chit_pkg::TMR_W-1:0] SETTLE = chit_pkg::TMR_W'(chit_pkg::SETTLE_CYC);
    localparam logic [chit_pkg::TMR_W-1:0] STRB = chit_pkg::TMR_W'(chit_pkg::STROBE_CYC);
    localparam logic [chit_pkg::TMR_W-1:0] ACC = chit_pkg::TMR_W'(chit_pkg::ACCESS_CYC);

    // synchronisers for the adapter pins
    logic svc_meta, svc_sync, svc_prev; // service-in stages
    logic [DW:0] bus_meta, bus_sync; // bus byte plus parity
    logic ev_rise, ev_fall; // one-cycle service-in edges
    // control register flags
    logic hw_transfer_flag, hw_transfer_second_flag, input_direction_flag;
    logic hw_active; // service-in belongs to transfer logic
    // capture path
    logic armed; // service-in seen, byte not yet captured
    logic [chit_pkg::TMR_W-1:0] dly_cnt; // settle count, counts up from zero
    logic dly_run; // settle delay in progress
    logic [chit_pkg::TMR_W-1:0] s1_cnt, s2_cnt, acc_cnt; // pulse timers
    logic rank_one_strobe, rank_two_strobe; // strobe pulses
    logic r1_start, r2_start, acc_start; // pulse launch events
    logic capture_control_flag, rank_one_full_flag;
    logic channel_svc_out_flag, svc_out_prev;
    logic hw_transfer_request_flag;
    logic stop_pending; // next service-in gets command-out
    logic [DW-1:0] input_rank_one, input_rank_two;
    logic [CW-1:0] byte_count_reg;
    // store routine
    chit_pkg::chit_step_t step;
    logic [AW-1:0] current_byte_address, last_byte_address;
    logic buf_ready; // buffer can take a word

    // two flip-flops on every pin before use; see RL21
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            svc_meta <= 1'b0;
            svc_sync <= 1'b0;
            svc_prev <= 1'b0;
            bus_meta <= '0;
            bus_sync <= '0;
        end else begin
            svc_meta <= svc_in_tag_i;
            svc_sync <= svc_meta;
            svc_prev <= svc_sync;
            bus_meta <= {bus_par_i, bus_in_i};
            bus_sync <= bus_meta;
        end
    end

    // edges taken from the second stage only; see RL21
    assign ev_rise = svc_sync & ~svc_prev;
    assign ev_fall = ~svc_sync & svc_prev;
    // control flags steer service-in; see RL4
    assign hw_active = hw_transfer_flag & input_direction_flag;

    // control register writes and error exit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hw_transfer_flag <= 1'b0;
            hw_transfer_second_flag <= 1'b0;
            input_direction_flag <= 1'b0;
            error_exit_o <= 1'b0;
        end else begin
            error_exit_o <= 1'b0;
            if (start_i && init_status_i != '0) begin
                // bad status: no data movement; see RL1
                error_exit_o <= 1'b1;
            end else if (start_i) begin
                // arm the hardware transfer; see RL2
                hw_transfer_flag <= 1'b1;
                input_direction_flag <= 1'b1;
                hw_transfer_second_flag <= 1'b0;
            end else begin
                // count carry ends input direction
                if (svc_out_prev && !channel_svc_out_flag && byte_count_reg == '1) begin
                    input_direction_flag <= 1'b0;
                end
                // transfer exit ends the hardware phase
                if (step == chit_pkg::ST_CMP && current_byte_address == last_byte_address) begin
                    hw_transfer_flag <= 1'b0;
                end
            end
        end
    end

    // byte counter: load count-1, advance on service-out fall
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            byte_count_reg <= '0;
            svc_out_prev <= 1'b0;
        end else begin
            svc_out_prev <= channel_svc_out_flag;
            if (start_i && init_status_i == '0) begin
                byte_count_reg <= req_count_i - CW'(1); // see RL2
            end else if (svc_out_prev && !channel_svc_out_flag) begin
                byte_count_reg <= byte_count_reg + CW'(1); // see RL12
            end
        end
    end

    // stop request: carry or external stop; see RL19
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stop_pending <= 1'b0;
        end else if (start_i) begin
            stop_pending <= 1'b0;
        end else if (stop_i && hw_transfer_flag) begin
            stop_pending <= 1'b1;
        end else if (svc_out_prev && !channel_svc_out_flag && byte_count_reg == '1) begin
            stop_pending <= 1'b1;
        end
    end

    // non-transfer service-in goes to general tag requests; see RL4
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tag_request_o <= 1'b0;
        end else begin
            tag_request_o <= ev_rise & ~hw_active & ~hw_transfer_flag;
        end
    end

    // accept service-in, then settle before capture; see RL5
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed <= 1'b0;
            dly_run <= 1'b0;
            dly_cnt <= '0;
        end else begin
            if (ev_rise && hw_active && !stop_pending) begin
                armed <= 1'b1;
            end else if (r1_start) begin
                armed <= 1'b0;
            end
            if (r1_start) begin
                dly_run <= 1'b0;
            end else if (armed && !dly_run && !rank_one_full_flag && !rank_one_strobe) begin
                // rank one busy holds the byte back
                dly_run <= 1'b1;
                dly_cnt <= '0;
            end else if (dly_run) begin
                dly_cnt <= dly_cnt + chit_pkg::TMR_W'(1);
            end
        end
    end

    // settle delay expires after the rounded-up count; see RL20
    assign r1_start = dly_run && dly_cnt == SETTLE - chit_pkg::TMR_W'(1);

    // rank-one strobe pulse and capture; see RL6
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rank_one_strobe <= 1'b0;
            s1_cnt <= '0;
            input_rank_one <= '0;
            check_o <= 1'b0;
        end else if (r1_start) begin
            rank_one_strobe <= 1'b1;
            s1_cnt <= STRB - chit_pkg::TMR_W'(1);
            input_rank_one <= bus_sync[DW-1:0];
            // check flag only clocked with no adapter selected
            if (!adapter_selected_i) begin
                check_o <= ~(^bus_sync);
            end
        end else if (s1_cnt != '0) begin
            s1_cnt <= s1_cnt - chit_pkg::TMR_W'(1);
        end else begin
            rank_one_strobe <= 1'b0;
        end
    end

    // capture flag: set by strobe, cleared by rank one full or service-in fall; see RL8
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            capture_control_flag <= 1'b0;
        end else if (r1_start) begin
            capture_control_flag <= 1'b1; // see RL6
        end else if (rank_one_full_flag || ev_fall) begin
            capture_control_flag <= 1'b0;
        end
    end

    // service-out and command-out tags toward the adapter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            channel_svc_out_flag <= 1'b0;
            cmd_out_tag_o <= 1'b0;
        end else if (start_i) begin
            // selection closes with service-out down; see RL3
            channel_svc_out_flag <= 1'b0;
            cmd_out_tag_o <= 1'b0;
        end else if (ev_fall || !svc_sync) begin
            // service-in gone ends both tags; see RL11
            channel_svc_out_flag <= 1'b0;
            cmd_out_tag_o <= 1'b0;
        end else if (stop_pending && hw_transfer_flag && ev_rise) begin
            cmd_out_tag_o <= 1'b1; // byte refused; see RL19
        end else if (capture_control_flag && svc_sync) begin
            channel_svc_out_flag <= 1'b1; // see RL7
        end
    end

    assign svc_out_tag_o = channel_svc_out_flag;

    // rank two loads only when empty; see RL18
    assign r2_start = rank_one_full_flag && !hw_transfer_request_flag && !rank_two_strobe;

    // rank-one-full flag; see RL8 and RL9
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rank_one_full_flag <= 1'b0;
        end else if (channel_svc_out_flag && !svc_out_prev && odd_byte_i) begin
            rank_one_full_flag <= 1'b1; // see RL8
        end else if (r2_start) begin
            rank_one_full_flag <= 1'b0; // see RL9
        end
    end

    // rank-two strobe pulse and byte move; see RL9
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rank_two_strobe <= 1'b0;
            s2_cnt <= '0;
            input_rank_two <= '0;
        end else if (r2_start) begin
            rank_two_strobe <= 1'b1;
            s2_cnt <= STRB - chit_pkg::TMR_W'(1);
            input_rank_two <= input_rank_one;
        end else if (s2_cnt != '0) begin
            s2_cnt <= s2_cnt - chit_pkg::TMR_W'(1);
        end else begin
            rank_two_strobe <= 1'b0;
        end
    end

    // register access pulse on rank-two read or output write; see RL16
    assign acc_start = (step == chit_pkg::ST_READ && buf_ready) || out_rank_wr_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_access_o <= 1'b0;
            acc_cnt <= '0;
            output_rank_one_o <= '0;
        end else begin
            if (out_rank_wr_i) begin
                output_rank_one_o <= out_rank_data_i;
            end
            if (acc_start) begin
                reg_access_o <= 1'b1;
                acc_cnt <= ACC - chit_pkg::TMR_W'(1);
            end else if (acc_cnt != '0) begin
                acc_cnt <= acc_cnt - chit_pkg::TMR_W'(1);
            end else begin
                reg_access_o <= 1'b0;
            end
        end
    end

    // request flag: rank-two strobe sets, access clears, set wins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hw_transfer_request_flag <= 1'b0;
        end else if (r2_start) begin
            hw_transfer_request_flag <= 1'b1; // see RL9
        end else if (acc_start) begin
            hw_transfer_request_flag <= 1'b0; // see RL17
        end
    end

    assign slice_request_o = hw_transfer_request_flag;

    // six-step store routine run in a granted slice; see RL13
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step <= chit_pkg::ST_IDLE;
            proc_busy_o <= 1'b0;
            xfer_exit_o <= 1'b0;
        end else begin
            xfer_exit_o <= 1'b0;
            case (step)
                chit_pkg::ST_IDLE: begin
                    if (slice_grant_i && hw_transfer_request_flag && hw_transfer_flag) begin
                        step <= chit_pkg::ST_LOAD;
                        proc_busy_o <= 1'b1;
                    end
                end
                chit_pkg::ST_LOAD: begin
                    step <= chit_pkg::ST_READ;
                end
                chit_pkg::ST_READ: begin
                    // full buffer stalls the routine here
                    if (buf_ready) begin
                        step <= chit_pkg::ST_SUM;
                    end
                end
                chit_pkg::ST_SUM: begin
                    step <= chit_pkg::ST_WRA;
                end
                chit_pkg::ST_WRA: begin
                    step <= chit_pkg::ST_WRB;
                end
                chit_pkg::ST_WRB: begin
                    step <= chit_pkg::ST_CMP;
                end
                chit_pkg::ST_CMP: begin
                    step <= chit_pkg::ST_IDLE;
                    proc_busy_o <= 1'b0; // see RL14
                    if (current_byte_address == last_byte_address) begin
                        xfer_exit_o <= 1'b1; // see RL15
                    end
                end
                default: begin
                    step <= chit_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // address registers: advanced once per stored byte except the last; see RL14
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            current_byte_address <= '0;
            last_byte_address <= '0;
        end else if (start_i && init_status_i == '0) begin
            current_byte_address <= first_addr_i;
            last_byte_address <= last_addr_i;
        end else if (step == chit_pkg::ST_CMP && current_byte_address != last_byte_address) begin
            current_byte_address <= current_byte_address + AW'(1);
        end
    end

    // buffer toward main storage absorbs write stalls; see RL13
    chit_buf #(
        .W(AW + DW)
    ) u_buf (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(step == chit_pkg::ST_READ),
        .in_data_i({current_byte_address, input_rank_two}),
        .in_ready_o(buf_ready),
        .out_valid_o(mem_valid_o),
        .out_data_o({mem_addr_o, mem_data_o}),
        .out_ready_i(mem_ready_i)
    );

    assign byte_count_o = byte_count_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // checks on the capture and store sequences
    sequence s_good_start;
        start_i && init_status_i == '0;
    endsequence
    sequence s_strobe_full;
        rank_one_strobe [*8] ##1 rank_one_strobe [*3] ##1 !rank_one_strobe;
    endsequence

    property p_error_abort;
        start_i && init_status_i != '0 |=> error_exit_o && $stable(input_direction_flag);
    endproperty
    a_error_abort: assert property (p_error_abort) else $error("error exit missing"); // see RL1

    property p_init_load;
        s_good_start |=> hw_transfer_flag && input_direction_flag && !hw_transfer_second_flag
            && byte_count_reg == $past(req_count_i) - CW'(1) && !svc_out_tag_o;
    endproperty
    a_init_load: assert property (p_init_load) else $error("init load wrong"); // see RL2

    property p_settle;
        $rose(rank_one_strobe) |-> $past(dly_cnt) == SETTLE - chit_pkg::TMR_W'(1);
    endproperty
    a_settle: assert property (p_settle) else $error("settle delay wrong"); // see RL5

    property p_strobe_width;
        $rose(rank_one_strobe) |-> s_strobe_full;
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong"); // see RL20

    property p_capture;
        $rose(rank_one_strobe) |-> capture_control_flag
            && input_rank_one == $past(bus_sync[DW-1:0]);
    endproperty
    a_capture: assert property (p_capture) else $error("capture wrong"); // see RL6

    property p_svc_fall;
        ev_fall |=> !svc_out_tag_o && !cmd_out_tag_o;
    endproperty
    a_svc_fall: assert property (p_svc_fall) else $error("service-out held"); // see RL11

    property p_count_step;
        $fell(channel_svc_out_flag) && !start_i |=>
            byte_count_reg == $past(byte_count_reg) + CW'(1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count step wrong"); // see RL12

    property p_access_clear;
        $rose(reg_access_o) && !$past(r2_start) |-> !hw_transfer_request_flag;
    endproperty
    a_access_clear: assert property (p_access_clear) else $error("request not cleared"); // see RL17

    property p_r2_inhibit;
        $rose(rank_two_strobe) |-> $past(!hw_transfer_request_flag) && hw_transfer_request_flag;
    endproperty
    a_r2_inhibit: assert property (p_r2_inhibit) else $error("rank two overwritten"); // see RL18

    property p_routine;
        step == chit_pkg::ST_LOAD |-> ##[5:1000] step == chit_pkg::ST_CMP;
    endproperty
    a_routine: assert property (p_routine) else $error("routine stuck"); // see RL13

    property p_exit;
        step == chit_pkg::ST_CMP && current_byte_address == last_byte_address
            |=> xfer_exit_o && !proc_busy_o;
    endproperty
    a_exit: assert property (p_exit) else $error("exit missing"); // see RL15

    property p_steer;
        ev_rise && !hw_transfer_flag |=> tag_request_o && !armed;
    endproperty
    a_steer: assert property (p_steer) else $error("service-in misrouted"); // see RL4
endmodule

// ### chit_adapter.sv
`timescale 1ns/1ps
// adapter model: one byte per service-in, held to the tag interlock
module chit_adapter (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // bench control
    input wire logic [7:0] limit_i,
    output logic [7:0] sent_o,
    output logic [7:0] stops_o,
    // channel pins
    input wire logic svc_out_tag_i,
    input wire logic cmd_out_tag_i,
    output logic svc_in_tag_o,
    output logic [7:0] bus_in_o,
    output logic bus_par_o
);
    // offer while below limit, only once both out tags are low
    initial begin
        {sent_o, stops_o, svc_in_tag_o, bus_in_o, bus_par_o} = '0;
        forever begin
            @(posedge clk_i);
            if (rst_n_i && sent_o + stops_o < limit_i && !svc_out_tag_i && !cmd_out_tag_i) begin
                repeat ($urandom_range(5, 1)) @(posedge clk_i);
                bus_in_o <= sent_o * 8'h3b + 8'h11;
                // odd-numbered bytes carry bad parity
                bus_par_o <= sent_o[0] ^ ~^(sent_o * 8'h3b + 8'h11);
                @(posedge clk_i);
                svc_in_tag_o <= 1'b1;
                while (!svc_out_tag_i && !cmd_out_tag_i) @(posedge clk_i);
                // a stop answer means the byte is skipped
                if (cmd_out_tag_i) stops_o <= stops_o + 8'h1;
                else sent_o <= sent_o + 8'h1;
                svc_in_tag_o <= 1'b0;
                bus_in_o <= ~bus_in_o;
            end
        end
    end
endmodule

// ### chit_top_tb.sv
`timescale 1ns/1ps
// random grant and storage timing around the adapter model
module chit_top_tb;
    // design ports, adapter control and counters
    logic clk_i = '0, rst_n_i = '0, start_i = '0, stop_i = '0, slice_grant_i = '0;
    logic mem_ready_i = '0, odd_byte_i = 1'h1, adapter_selected_i = 1'h1, out_rank_wr_i = '0;
    logic [7:0] init_status_i = '0, out_rank_data_i = '0, bus_in_i, lim = '0, sent, stops;
    logic [15:0] req_count_i = '0, first_addr_i = '0, last_addr_i = '0, byte_count_o, mem_addr_o;
    logic svc_in_tag_i, bus_par_i, svc_out_tag_o, cmd_out_tag_o, slice_request_o, tag_request_o;
    logic proc_busy_o, check_o, reg_access_o, error_exit_o, xfer_exit_o, mem_valid_o;
    logic acc_d = '0, cmd_d = '0;
    logic [7:0] output_rank_one_o, mem_data_o;
    int mismatches = 0, compares = 0, cyc = 0, gp = 0, n, words, exits, errs, pulses, cmds;
    int tags = 0, base = 0;
    chit_top DUT (.clk_i, .rst_n_i, .start_i, .init_status_i, .req_count_i, .first_addr_i,
        .last_addr_i, .odd_byte_i, .adapter_selected_i, .stop_i, .svc_in_tag_i, .bus_in_i,
        .bus_par_i, .svc_out_tag_o, .cmd_out_tag_o, .slice_grant_i, .out_rank_wr_i,
        .out_rank_data_i, .slice_request_o, .tag_request_o, .proc_busy_o, .reg_access_o,
        .error_exit_o, .xfer_exit_o, .check_o, .byte_count_o, .output_rank_one_o,
        .mem_valid_o, .mem_addr_o, .mem_data_o, .mem_ready_i);
    chit_adapter ADP (.clk_i, .rst_n_i, .limit_i(lim), .sent_o(sent), .stops_o(stops),
        .svc_out_tag_i(svc_out_tag_o), .cmd_out_tag_i(cmd_out_tag_o),
        .svc_in_tag_o(svc_in_tag_i), .bus_in_o(bus_in_i), .bus_par_o(bus_par_i));
    // 200 mhz clock
    always #2.5 clk_i = ~clk_i;
    // grants at gp percent, storage ready at 70 percent
    always @(negedge clk_i) begin
        slice_grant_i <= slice_request_o && $urandom_range(99) < gp;
        mem_ready_i <= $urandom_range(99) < 70;
    end
    // timeout, stored word order, event counting
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            finish_test();
        end
        if (mem_valid_o === 1'h1 && mem_ready_i) begin
            chk("mem_addr", 16'(first_addr_i + words), mem_addr_o);
            chk("mem_data", 8'((base + words) * 8'h3b + 8'h11), mem_data_o);
            words++;
        end
        exits += xfer_exit_o;
        errs += error_exit_o;
        pulses += reg_access_o && !acc_d;
        cmds += cmd_out_tag_o && !cmd_d;
        tags += tag_request_o;
        acc_d <= reg_access_o;
        cmd_d <= cmd_out_tag_o;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // start an n-byte transfer with status st; the adapter offers k bytes
    task automatic run(input logic [7:0] st, input int k);
        {words, exits, errs, pulses, cmds, tags} = '0;
        first_addr_i = 16'($urandom);
        last_addr_i = 16'(first_addr_i + n - 1);
        req_count_i = 16'(n);
        init_status_i = st;
        start_i = 1'h1;
        @(negedge clk_i);
        start_i = '0;
        base = sent;
        lim = 8'(sent + k);
        for (int i = 0; i < 3000 && exits + errs == 0 && (k == n || k == 0 || words < k); i++)
            @(negedge clk_i);
        repeat (30) @(negedge clk_i);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // reset, then access pulse, error abort, slow and fast transfers, stop
    initial begin
        void'($urandom(34));
        repeat (5) @(negedge clk_i);
        rst_n_i = 1'h1;
        out_rank_data_i = 8'($urandom);
        out_rank_wr_i = 1'h1;
        @(negedge clk_i);
        out_rank_wr_i = '0;
        repeat (10) @(negedge clk_i);
        chk("out_rank", out_rank_data_i, output_rank_one_o);
        chk("access", 1, pulses);
        $display("test access done");
        n = 4;
        run(8'($urandom_range(255, 1)), 0);
        chk("error_exit", 1, errs);
        $display("test error done");
        for (gp = 5; gp < 100; gp += 90) begin
            n = $urandom_range(8, 3);
            run('0, n);
            chk("stored", n, words);
            chk("exit", 1, exits);
            chk("pulses", n, pulses);
            chk("count", 16'(2 * n - 1), byte_count_o);
            chk("check", 0, check_o);
            chk("tag_req", 0, tags);
            chk("busy", 0, proc_busy_o);
            chk("request", 0, slice_request_o);
            $display("test transfer done");
        end
        n = 8;
        run('0, 3);
        stop_i = 1'h1;
        lim = lim + 8'h1;
        repeat (100) @(negedge clk_i);
        chk("stop_answer", 1, cmds);
        chk("stop_skip", 3, words);
        $display("test stop done");
        // reset in mid-run clears the transfer flags, so a new byte is a tag request
        rst_n_i = '0;
        repeat (2) @(negedge clk_i);
        rst_n_i = 1'h1;
        tags = 0;
        lim = lim + 8'h1;
        repeat (40) @(negedge clk_i);
        chk("tag_req", 1, tags);
        $display("test reset done");
        finish_test();
    end
endmodule
